/* File: dv/lds_props.sv */
// lds_props: port assertions for the limit dac value selector.
// assumes a bind onto lds_top; settings are mirrored from the command port.

`timescale 1ns/1ps
`default_nettype none

module lds_props
    import lds_pkg::*;
(
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    // operating state
    input  wire logic       output_on,
    input  wire logic       current_mode,
    input  wire logic [7:0] vlim_setpoint,
    input  wire logic [7:0] ilim_setpoint,
    // commands and storage
    input  wire logic       cmd_valid,
    input  wire logic       cmd_write,
    input  wire logic [2:0] cmd_sel,
    input  wire logic [7:0] cmd_wdata,
    input  wire logic       resp_valid,
    input  wire logic [7:0] resp_data,
    input  wire logic       resp_err,
    input  wire logic       security_initialise_command,
    input  wire logic       save_variables_command,
    input  wire logic       nv_save_stb,
    input  wire logic       nv_load_stb,
    input  wire lds_cfg_t   nv_load_data,
    // dac codes
    input  wire logic [7:0] vlim_dac_code,
    input  wire logic [7:0] ilim_dac_code
);
    logic [3:0] ctrl_q;
    logic       vfix_q;
    logic       ifix_q;

    // ------------------------------------------------------------------
    // mirror of the nibble and fix bits, init beats load beats write
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n || security_initialise_command) begin
            ctrl_q <= 4'h0;
            vfix_q <= 1'b0;
            ifix_q <= 1'b0;
        end else if (nv_load_stb) begin
            ctrl_q <= nv_load_data.off_state_limit_control;
            vfix_q <= nv_load_data.voltage_protection_config[7];
            ifix_q <= nv_load_data.current_protection_config[7];
        end else if (cmd_valid && cmd_write) begin
            if (cmd_sel == 3'h0) ctrl_q <= cmd_wdata[3:0];
            if (cmd_sel == 3'h5) ifix_q <= cmd_wdata[7];
            if (cmd_sel == 3'h6) vfix_q <= cmd_wdata[7];
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    // ------------------------------------------------------------------
    // command port and storage strobes
    // ------------------------------------------------------------------
    a_resp_follows: assert property (cmd_valid |=> resp_valid)
        else $error("command not answered");
    a_resp_quiet: assert property (!cmd_valid |=> !resp_valid)
        else $error("answer without a command");
    a_err_unmapped: assert property (
        (cmd_valid && cmd_sel == 3'h7) |=> resp_err && resp_data == 8'h00)
        else $error("unmapped select not flagged");
    a_err_mapped: assert property ((cmd_valid && cmd_sel != 3'h7) |=> !resp_err)
        else $error("mapped select flagged");
    a_save_strobe: assert property (
        save_variables_command |=> nv_save_stb)
        else $error("save strobe missing");
    a_save_quiet: assert property (
        !save_variables_command |=> !nv_save_stb)
        else $error("save strobe without command");

    // ------------------------------------------------------------------
    // dac code selection
    // ------------------------------------------------------------------
    a_off_zero: assert property (
        (!output_on && ctrl_q == 4'h0) |=> vlim_dac_code == 8'h00
        && ilim_dac_code == 8'h00)
        else $error("off state codes not zero");
    a_vmax_off: assert property (
        (!output_on && ctrl_q[0] && !current_mode) |=> vlim_dac_code == 8'hff)
        else $error("voltage limit not at maximum");
    a_imax_off: assert property (
        (!output_on && ctrl_q[1] && current_mode) |=> ilim_dac_code == 8'hff)
        else $error("current limit not at maximum");
    a_on_vset: assert property (
        (output_on && !(vfix_q && current_mode))
        |=> vlim_dac_code == $past(vlim_setpoint))
        else $error("voltage limit off setpoint");
    a_on_iset: assert property (
        (output_on && !(ifix_q && !current_mode))
        |=> ilim_dac_code == $past(ilim_setpoint))
        else $error("current limit off setpoint");
endmodule : lds_props

bind lds_top lds_props u_props (
    .sys_clk(sys_clk), .arst_n(arst_n), .output_on(output_on),
    .current_mode(current_mode), .vlim_setpoint(vlim_setpoint),
    .ilim_setpoint(ilim_setpoint), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata),
    .resp_valid(resp_valid), .resp_data(resp_data), .resp_err(resp_err),
    .security_initialise_command(security_initialise_command),
    .save_variables_command(save_variables_command),
    .nv_save_stb(nv_save_stb), .nv_load_stb(nv_load_stb),
    .nv_load_data(nv_load_data), .vlim_dac_code(vlim_dac_code),
    .ilim_dac_code(ilim_dac_code)
);

`default_nettype wire

/* File: dv/lds_top_tb_top.sv */
// lds_top_tb_top: self-checking bench for the limit dac value selector.
// assumes lds_pkg and lds_top; inputs change on the falling clock edge.

`timescale 1ns/1ps
`default_nettype none

module lds_top_tb_top
    import lds_pkg::*;
;

    logic       sys_clk = 1'b0;
    logic       arst_n = 1'b0;
    logic       output_on = 1'b0;
    logic       current_mode = 1'b0;
    logic [7:0] vlim_setpoint = 8'h00;
    logic [7:0] ilim_setpoint = 8'h00;
    logic       cmd_valid = 1'b0;
    logic       cmd_write = 1'b0;
    logic [2:0] cmd_sel = 3'h0;
    logic [7:0] cmd_wdata = 8'h00;
    logic       resp_valid, resp_err, nv_save_stb;
    logic [7:0] resp_data, vlim_dac_code, ilim_dac_code;
    logic       security_initialise_command = 1'b0;
    logic       save_variables_command = 1'b0;
    logic       nv_load_stb = 1'b0;
    lds_cfg_t   nv_load_data = LDS_CFG_RST;
    lds_cfg_t   nv_save_data;
    lds_cfg_t   exp_cfg = LDS_CFG_RST;
    logic [31:0] seed = 32'h66daca05;
    int         mismatches = 0;
    int         cmp_count = 0;

    // ------------------------------------------------------------------
    // clock, device and helpers
    // ------------------------------------------------------------------
    always #50 sys_clk = ~sys_clk;

    lds_top u_dut (
        .sys_clk(sys_clk), .arst_n(arst_n), .output_on(output_on),
        .current_mode(current_mode), .vlim_setpoint(vlim_setpoint),
        .ilim_setpoint(ilim_setpoint), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata),
        .resp_valid(resp_valid), .resp_data(resp_data), .resp_err(resp_err),
        .security_initialise_command(security_initialise_command),
        .save_variables_command(save_variables_command),
        .nv_save_stb(nv_save_stb), .nv_save_data(nv_save_data),
        .nv_load_stb(nv_load_stb), .nv_load_data(nv_load_data),
        .vlim_dac_code(vlim_dac_code), .ilim_dac_code(ilim_dac_code)
    );

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    // expected voltage code: maximum wins over the stored off code
    function automatic logic [7:0] exp_v(input logic on, input logic cm);
        if (on) return (exp_cfg.voltage_protection_config[7] && cm) ?
            exp_cfg.on_voltage_limit_code : vlim_setpoint;
        if (exp_cfg.off_state_limit_control[0] && !cm) return LDS_DAC_MAX;
        if (exp_cfg.off_state_limit_control[2] && cm)
            return exp_cfg.off_voltage_limit_code;
        return LDS_DAC_ZERO;
    endfunction : exp_v

    function automatic logic [7:0] exp_i(input logic on, input logic cm);
        if (on) return (exp_cfg.current_protection_config[7] && !cm) ?
            exp_cfg.on_current_limit_code : ilim_setpoint;
        if (exp_cfg.off_state_limit_control[1] && cm) return LDS_DAC_MAX;
        if (exp_cfg.off_state_limit_control[3] && !cm)
            return exp_cfg.off_current_limit_code;
        return LDS_DAC_ZERO;
    endfunction : exp_i

    function automatic logic [7:0] rd_exp(input logic [2:0] s);
        if (s == 3'h0) return {4'h0, exp_cfg.off_state_limit_control};
        if (s == 3'h7) return 8'h00;
        return exp_cfg[8*(6-s) +: 8];
    endfunction : rd_exp

    task automatic chk(input logic [63:0] got, input logic [63:0] exp,
                       input string what);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask : chk

    // one command; cmd_valid stays up for back to back
    task automatic do_cmd(input logic wr, input logic [2:0] s,
                          input logic [7:0] wd);
        logic [7:0] ed;
        ed = wr ? 8'h00 : rd_exp(s);
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_sel = s;
        cmd_wdata = wd;
        @(posedge sys_clk);
        @(negedge sys_clk);
        if (wr && s == 3'h0) exp_cfg.off_state_limit_control = wd[3:0];
        else if (wr && s != 3'h7) exp_cfg[8*(6-s) +: 8] = wd;
        chk(resp_valid, 1'b1, "answer strobe");
        chk(resp_err, s == 3'h7, "unmapped flag");
        chk(resp_data, ed, "answer data");
    endtask : do_cmd

    task automatic query_all;
        for (int s = 0; s < 8; s++) do_cmd(1'b0, s[2:0], 8'h00);
    endtask : query_all

    task automatic check_dac(input logic on, input logic cm);
        cmd_valid = 1'b0;
        output_on = on;
        current_mode = cm;
        seed = lfsr_next(seed);
        {ilim_setpoint, vlim_setpoint} = seed[15:0];
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(vlim_dac_code, exp_v(on, cm), "voltage code");
        chk(ilim_dac_code, exp_i(on, cm), "current code");
    endtask : check_dac

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up

    // ------------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        wrap_up();
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        arst_n = 1'b1;
        query_all();
        check_dac(1'b0, 1'b1);
        do_cmd(1'b1, 3'h0, 8'hfa);
        do_cmd(1'b0, 3'h0, 8'h00);
        // every nibble with random codes, fix bits and mode pairs
        for (int n = 0; n < 16; n++) begin
            for (int s = 1; s < 7; s++) begin
                seed = lfsr_next(seed);
                do_cmd(1'b1, s[2:0], seed[7:0]);
            end
            do_cmd(1'b1, 3'h0, {seed[11:8], n[3:0]});
            query_all();
            for (int k = 0; k < 4; k++) check_dac(k[1], k[0]);
        end
        // save with a same cycle write in the image
        save_variables_command = 1'b1;
        do_cmd(1'b1, 3'h3, 8'h5a);
        save_variables_command = 1'b0;
        chk(nv_save_stb, 1'b1, "save strobe");
        chk(nv_save_data, exp_cfg, "save image");
        // restore an image from storage
        cmd_valid = 1'b0;
        seed = lfsr_next(seed);
        nv_load_data = {seed[19:0], lfsr_next(seed)};
        nv_load_stb = 1'b1;
        @(posedge sys_clk);
        @(negedge sys_clk);
        nv_load_stb = 1'b0;
        exp_cfg = nv_load_data;
        query_all();
        for (int k = 0; k < 4; k++) check_dac(k[1], k[0]);
        // security initialise beats a same cycle write
        security_initialise_command = 1'b1;
        do_cmd(1'b1, 3'h1, 8'h12);
        security_initialise_command = 1'b0;
        exp_cfg = LDS_CFG_RST;
        query_all();
        check_dac(1'b0, 1'b0);
        wrap_up();
    end
endmodule : lds_top_tb_top

`default_nettype wire

/* File: verilog/lds_channel_sel.sv */
// lds_channel_sel: picks the dac code of one limit channel.
// assumes stable levels: settings from the main block's flip-flops, on state, mode and setpoints from its ports.

`timescale 1ns/1ps
`default_nettype none

module lds_channel_sel
    import lds_pkg::*;
#(
    parameter int W = LDS_DAC_W
) (
    // operating state
    input  wire logic         out_on,
    input  wire logic         own_mode,
    // off-state overrides
    input  wire logic         max_en,
    input  wire logic         off_en,
    input  wire logic [W-1:0] off_code,
    // on-state override
    input  wire logic         fix_en,
    input  wire logic [W-1:0] on_code,
    // normal setpoint
    input  wire logic [W-1:0] setpoint,
    // chosen code
    output logic      [W-1:0] code
);

    // ------------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------------
    if (W != LDS_DAC_W) begin : g_bad_w
        $error("lds_channel_sel: width must match the limit dac");
    end

    // ------------------------------------------------------------------
    // selection
    // ------------------------------------------------------------------
    // off: max beats the stored code, nothing selected gives zero;
    // on: fixed code in the other mode, else the normal setpoint
    always_comb begin
        code = W'(LDS_DAC_ZERO);
        if (!out_on) begin
            if (max_en && own_mode) begin
                code = W'(LDS_DAC_MAX);
            end else if (off_en && !own_mode) begin
                code = off_code;
            end
        end else if (fix_en && !own_mode) begin
            code = on_code;
        end else begin
            code = setpoint;
        end
    end

endmodule : lds_channel_sel

`default_nettype wire

/* File: verilog/lds_pkg.sv */
// lds_pkg: constants and types for the limit dac value selector.
// assumes one 10 mhz clock; settings reach the block as decoded commands.

`default_nettype none

package lds_pkg;

    // ------------------------------------------------------------------
    // widths and codes
    // ------------------------------------------------------------------
    localparam int         LDS_DAC_W    = 8;       // limit dac code width
    localparam int         LDS_CTRL_W   = 4;       // off-state control width
    localparam logic [7:0] LDS_DAC_MAX  = 8'hff;   // full scale dac code
    localparam logic [7:0] LDS_DAC_ZERO = 8'h00;   // zero dac code

    // ------------------------------------------------------------------
    // values after reset and after security initialise
    // ------------------------------------------------------------------
    localparam logic [3:0] LDS_CTRL_RST  = 4'h0;   // off-state control
    localparam logic [7:0] LDS_ILIM_RST  = 8'h80;  // current limit codes, 128
    localparam logic [7:0] LDS_VLIM_RST  = 8'h00;  // voltage limit codes
    localparam logic [7:0] LDS_PROT_RST  = 8'h00;  // protection config bytes

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int LDS_CTRL_V_MAX_BIT = 0;  // voltage limit max, voltage mode
    localparam int LDS_CTRL_I_MAX_BIT = 1;  // current limit max, current mode
    localparam int LDS_CTRL_V_OFF_BIT = 2;  // voltage limit from off code
    localparam int LDS_CTRL_I_OFF_BIT = 3;  // current limit from off code
    localparam int LDS_PROT_FIX_BIT   = 7;  // fixed limit while output on

    // ------------------------------------------------------------------
    // channel indices of the selector loop
    // ------------------------------------------------------------------
    localparam int LDS_CH_V = 0;
    localparam int LDS_CH_I = 1;

    // ------------------------------------------------------------------
    // register select codes of the command port
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        LDS_SEL_OFF_STATE_LIMIT_CONTROL   = 3'h0,
        LDS_SEL_OFF_CURRENT_LIMIT_CODE    = 3'h1,
        LDS_SEL_OFF_VOLTAGE_LIMIT_CODE    = 3'h2,
        LDS_SEL_ON_CURRENT_LIMIT_CODE     = 3'h3,
        LDS_SEL_ON_VOLTAGE_LIMIT_CODE     = 3'h4,
        LDS_SEL_CURRENT_PROTECTION_CONFIG = 3'h5,
        LDS_SEL_VOLTAGE_PROTECTION_CONFIG = 3'h6
    } lds_sel_t;

    // ------------------------------------------------------------------
    // configuration image, also the persistent storage word
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [3:0] off_state_limit_control;
        logic [7:0] off_current_limit_code;
        logic [7:0] off_voltage_limit_code;
        logic [7:0] on_current_limit_code;
        logic [7:0] on_voltage_limit_code;
        logic [7:0] current_protection_config;
        logic [7:0] voltage_protection_config;
    } lds_cfg_t;

    localparam lds_cfg_t LDS_CFG_RST = '{
        off_state_limit_control   : LDS_CTRL_RST,
        off_current_limit_code    : LDS_ILIM_RST,
        off_voltage_limit_code    : LDS_VLIM_RST,
        on_current_limit_code     : LDS_ILIM_RST,
        on_voltage_limit_code     : LDS_VLIM_RST,
        current_protection_config : LDS_PROT_RST,
        voltage_protection_config : LDS_PROT_RST
    };

endpackage : lds_pkg

`default_nettype wire

/* File: verilog/lds_top.sv */
// lds_top: limit dac value selector of a programmable supply.
// assumes decoded commands and queries arrive on a simple strobe port
// synchronous to sys_clk, and that persistent storage lives outside.
//
// Contract
// - Off-state nibble zero: both limit dacs get zero while output is off.
// - Nibble bit 0: voltage limit to maximum in voltage mode, output off.
// - Nibble bit 1: current limit to maximum in current mode, output off.
// - Nibble bit 2: voltage limit uses stored off-state code, output off.
// - Nibble bit 3: current limit uses stored off-state code, output off.
// - Maximum and stored-code bits both set: the maximum code wins.
// - Off-state control is four bits, written and read as one hex digit.
// - Security initialise clears the nibble to zero, its default.
// - Off current code only when off, voltage mode, its bit set.
// - Off voltage code only when off, current mode, its bit set.
// - On current code when on, voltage mode, current config bit 7 set.
// - On voltage code when on, current mode, voltage config bit 7 set.
// - Off and on current limit codes default to 128.
// - Off and on voltage limit codes default to zero.
// - A query returns the stored byte as programmed.
// - Save commits the configuration for later power-up cycles.
// - Current config bit 7 fixes the current limit while output on.
// - Voltage config bit 7 fixes the voltage limit while output on.

`timescale 1ns/1ps
`default_nettype none

module lds_top
    import lds_pkg::*;
(
    // clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 arst_n,
    // supply operating state
    input  wire logic                 output_on,
    input  wire logic                 current_mode,
    input  wire logic [LDS_DAC_W-1:0] vlim_setpoint,
    input  wire logic [LDS_DAC_W-1:0] ilim_setpoint,
    // setting commands and queries
    input  wire logic                 cmd_valid,
    input  wire logic                 cmd_write,
    input  wire logic [2:0]           cmd_sel,
    input  wire logic [7:0]           cmd_wdata,
    output logic                      resp_valid,
    output logic      [7:0]           resp_data,
    output logic                      resp_err,
    // system commands
    input  wire logic                 security_initialise_command,
    input  wire logic                 save_variables_command,
    // persistent storage
    output logic                      nv_save_stb,
    output lds_cfg_t                  nv_save_data,
    input  wire logic                 nv_load_stb,
    input  wire lds_cfg_t             nv_load_data,
    // limit dac codes
    output logic      [LDS_DAC_W-1:0] vlim_dac_code,
    output logic      [LDS_DAC_W-1:0] ilim_dac_code
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        lds_cfg_t             cfg;
        logic [LDS_DAC_W-1:0] vdac;
        logic [LDS_DAC_W-1:0] idac;
        logic                 resp_valid;
        logic [7:0]           resp_data;
        logic                 resp_err;
        logic                 save_stb;
        lds_cfg_t             save_data;
    } lds_state_t;

    localparam lds_state_t ST_RST = '{
        cfg        : LDS_CFG_RST,
        vdac       : LDS_DAC_ZERO,
        idac       : LDS_DAC_ZERO,
        resp_valid : 1'b0,
        resp_data  : 8'h00,
        resp_err   : 1'b0,
        save_stb   : 1'b0,
        save_data  : LDS_CFG_RST
    };

    lds_state_t st_q;
    lds_state_t st_d;

    // ------------------------------------------------------------------
    // per-channel selector inputs
    // ------------------------------------------------------------------
    logic [1:0]                own_mode;
    logic [1:0]                max_en;
    logic [1:0]                off_en;
    logic [1:0]                fix_en;
    logic [1:0][LDS_DAC_W-1:0] off_code;
    logic [1:0][LDS_DAC_W-1:0] on_code;
    logic [1:0][LDS_DAC_W-1:0] setpoint;
    logic [1:0][LDS_DAC_W-1:0] code;

    // voltage channel: own mode is voltage mode
    always_comb begin
        own_mode[LDS_CH_V] = !current_mode;
        own_mode[LDS_CH_I] = current_mode;
    end

    // off-state enables come from the control nibble
    always_comb begin
        max_en[LDS_CH_V] =
            st_q.cfg.off_state_limit_control[LDS_CTRL_V_MAX_BIT];
        max_en[LDS_CH_I] =
            st_q.cfg.off_state_limit_control[LDS_CTRL_I_MAX_BIT];
        off_en[LDS_CH_V] =
            st_q.cfg.off_state_limit_control[LDS_CTRL_V_OFF_BIT];
        off_en[LDS_CH_I] =
            st_q.cfg.off_state_limit_control[LDS_CTRL_I_OFF_BIT];
    end

    // on-state fixed limits come from bit 7 of each protection byte
    always_comb begin
        fix_en[LDS_CH_V] =
            st_q.cfg.voltage_protection_config[LDS_PROT_FIX_BIT];
        fix_en[LDS_CH_I] =
            st_q.cfg.current_protection_config[LDS_PROT_FIX_BIT];
    end

    // stored codes and normal setpoints per channel
    always_comb begin
        off_code[LDS_CH_V] = st_q.cfg.off_voltage_limit_code;
        off_code[LDS_CH_I] = st_q.cfg.off_current_limit_code;
        on_code[LDS_CH_V]  = st_q.cfg.on_voltage_limit_code;
        on_code[LDS_CH_I]  = st_q.cfg.on_current_limit_code;
        setpoint[LDS_CH_V] = vlim_setpoint;
        setpoint[LDS_CH_I] = ilim_setpoint;
    end

    // ------------------------------------------------------------------
    // selectors, one per limit channel
    // ------------------------------------------------------------------
    for (genvar ch = 0; ch < 2; ch++) begin : g_ch
        lds_channel_sel #(
            .W        (LDS_DAC_W)
        ) u_sel (
            .out_on   (output_on),
            .own_mode (own_mode[ch]),
            .max_en   (max_en[ch]),
            .off_en   (off_en[ch]),
            .off_code (off_code[ch]),
            .fix_en   (fix_en[ch]),
            .on_code  (on_code[ch]),
            .setpoint (setpoint[ch]),
            .code     (code[ch])
        );
    end

    // ------------------------------------------------------------------
    // query read mux
    // ------------------------------------------------------------------
    logic [7:0] rd_data;
    logic       rd_hit;

    // stored bytes read back exactly as programmed; nibble zero-extended
    always_comb begin
        rd_hit  = 1'b1;
        rd_data = 8'h00;
        case (cmd_sel)
            LDS_SEL_OFF_STATE_LIMIT_CONTROL: begin
                rd_data = {4'h0, st_q.cfg.off_state_limit_control};
            end
            LDS_SEL_OFF_CURRENT_LIMIT_CODE: begin
                rd_data = st_q.cfg.off_current_limit_code;
            end
            LDS_SEL_OFF_VOLTAGE_LIMIT_CODE: begin
                rd_data = st_q.cfg.off_voltage_limit_code;
            end
            LDS_SEL_ON_CURRENT_LIMIT_CODE: begin
                rd_data = st_q.cfg.on_current_limit_code;
            end
            LDS_SEL_ON_VOLTAGE_LIMIT_CODE: begin
                rd_data = st_q.cfg.on_voltage_limit_code;
            end
            LDS_SEL_CURRENT_PROTECTION_CONFIG: begin
                rd_data = st_q.cfg.current_protection_config;
            end
            LDS_SEL_VOLTAGE_PROTECTION_CONFIG: begin
                rd_data = st_q.cfg.voltage_protection_config;
            end
            default: begin
                rd_hit  = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    // priority: security initialise, then storage load, then a write
    always_comb begin
        st_d = st_q;

        // dac codes are registered from the selectors every cycle
        st_d.vdac = code[LDS_CH_V];
        st_d.idac = code[LDS_CH_I];

        // one-cycle strobes fall back unless raised below
        st_d.resp_valid = 1'b0;
        st_d.resp_err   = 1'b0;
        st_d.save_stb   = 1'b0;

        // command writes store into the configuration
        if (cmd_valid && cmd_write) begin
            case (cmd_sel)
                LDS_SEL_OFF_STATE_LIMIT_CONTROL: begin
                    st_d.cfg.off_state_limit_control =
                        cmd_wdata[LDS_CTRL_W-1:0];
                end
                LDS_SEL_OFF_CURRENT_LIMIT_CODE: begin
                    st_d.cfg.off_current_limit_code = cmd_wdata;
                end
                LDS_SEL_OFF_VOLTAGE_LIMIT_CODE: begin
                    st_d.cfg.off_voltage_limit_code = cmd_wdata;
                end
                LDS_SEL_ON_CURRENT_LIMIT_CODE: begin
                    st_d.cfg.on_current_limit_code = cmd_wdata;
                end
                LDS_SEL_ON_VOLTAGE_LIMIT_CODE: begin
                    st_d.cfg.on_voltage_limit_code = cmd_wdata;
                end
                LDS_SEL_CURRENT_PROTECTION_CONFIG: begin
                    st_d.cfg.current_protection_config = cmd_wdata;
                end
                LDS_SEL_VOLTAGE_PROTECTION_CONFIG: begin
                    st_d.cfg.voltage_protection_config = cmd_wdata;
                end
                default: begin
                    st_d.cfg = st_q.cfg;  // unmapped write ignored
                end
            endcase
        end

        // every command answers next cycle; queries carry the data
        if (cmd_valid) begin
            st_d.resp_valid = 1'b1;
            st_d.resp_err   = !rd_hit;
            st_d.resp_data  = cmd_write ? 8'h00 : rd_data;
        end

        // restore from persistent storage after power-up
        if (nv_load_stb) begin
            st_d.cfg = nv_load_data;
        end

        // security initialise returns every setting to its default
        if (security_initialise_command) begin
            st_d.cfg = LDS_CFG_RST;
        end

        // save commits the settings now in force, after this cycle's
        // changes, so a same-cycle write is part of the saved image
        if (save_variables_command) begin
            st_d.save_stb  = 1'b1;
            st_d.save_data = st_d.cfg;
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    // defaults hold 128 for current codes and zero for voltage codes
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= ST_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    always_comb begin
        vlim_dac_code = st_q.vdac;
        ilim_dac_code = st_q.idac;
        resp_valid    = st_q.resp_valid;
        resp_data     = st_q.resp_data;
        resp_err      = st_q.resp_err;
        nv_save_stb   = st_q.save_stb;
        nv_save_data  = st_q.save_data;
    end

endmodule : lds_top

`default_nettype wire
